/* logic/rrbs_top.sv */
// Rotate-right and borrow-subtract datapath behind an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "rrbs_regs.svh"
module rrbs_top
  import rrbs_pkg::*;
(
  input  logic                     clk,
  input  logic                     sys_rst,
  input  logic [`RRBS_ADDR_W-1:0]  s_axi_awaddr,
  input  logic [2:0]               s_axi_awprot,
  input  logic                     s_axi_awvalid,
  output logic                     s_axi_awready,
  input  logic [`RRBS_DATA_W-1:0]  s_axi_wdata,
  input  logic [3:0]               s_axi_wstrb,
  input  logic                     s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  logic                     s_axi_bready,
  input  logic [`RRBS_ADDR_W-1:0]  s_axi_araddr,
  input  logic [2:0]               s_axi_arprot,
  input  logic                     s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [`RRBS_DATA_W-1:0]  s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  logic                     s_axi_rready
);

  logic [`RRBS_BYTE_W-1:0] acc;
  rrbs_flags_t             flags;
  logic [`RRBS_IDX_W-1:0]  mem_idx;
  logic [`RRBS_BYTE_W-1:0] mem [`RRBS_MEM_DEPTH];
  rrbs_op_t                last_op;
  logic                    bad_op;
  logic                    aw_full;
  logic                    w_full;
  logic [`RRBS_ADDR_W-1:0] aw_addr;
  logic [`RRBS_DATA_W-1:0] w_data;
  logic                    w_lane0;
  logic                    wr_fire;
  logic                    wr_lo;
  logic                    exec;
  rrbs_op_t                cmd_op;
  logic [`RRBS_BYTE_W-1:0] cur_mem;
  logic [`RRBS_BYTE_W-1:0] rot_res;
  logic                    rot_c;
  logic                    via_c;
  logic [`RRBS_BYTE_W-1:0] sub_res;
  rrbs_flags_t             sub_flags;
  logic [`RRBS_DATA_W-1:0] next_rdata;
  logic [1:0]              next_rresp;
  logic [1:0]              next_bresp;

  // Write commit and command decode
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid;
  assign wr_lo   = wr_fire & w_lane0;
  assign cmd_op  = rrbs_op_t'(w_data[`RRBS_OP_W-1:0]);
  assign exec    = wr_lo && (aw_addr == `RRBS_OFF_CMD);
  assign cur_mem = mem[mem_idx];
  assign via_c   = (cmd_op == OP_ROTRC) || (cmd_op == OP_ROTRC_A);

  rrbs_rotate u_rotate (
    .operand   (cur_mem),
    .carry_in  (flags.carry),
    .via_carry (via_c),
    .result    (rot_res),
    .carry_out (rot_c)
  );

  rrbs_subc u_subc (
    .acc_in    (acc),
    .mem_in    (cur_mem),
    .carry_in  (flags.carry),
    .chain_in  (flags.zero),
    .result    (sub_res),
    .flags_out (sub_flags)
  );

  // Write address channel holding register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_full       <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr       <= `RRBS_RST_BYTE;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full       <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      aw_full       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel holding register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      w_full       <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data       <= {`RRBS_DATA_W{1'b0}};
      w_lane0      <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full       <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      w_full       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, error on unmapped address
  always_comb
  begin
    case (aw_addr)
      `RRBS_OFF_ACC, `RRBS_OFF_MIDX, `RRBS_OFF_MDATA,
      `RRBS_OFF_CMD, `RRBS_OFF_FLAGS, `RRBS_OFF_STAT: next_bresp = `RRBS_RESP_OKAY;
      default:                                         next_bresp = `RRBS_RESP_ERR;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RRBS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Accumulator: software write or operation result
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc <= `RRBS_RST_BYTE;
    else if (wr_lo && aw_addr == `RRBS_OFF_ACC)
      acc <= w_data[`RRBS_BYTE_W-1:0];
    else if (exec)
    begin
      case (cmd_op)
        OP_ROTR_A:  acc <= rot_res;
        OP_ROTRC_A: acc <= rot_res;
        OP_SBC_A:   acc <= sub_res;
        default:    acc <= acc;
      endcase
    end
  end

  // Flags: software write or operation result
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags <= `RRBS_RST_FLAGS;
    else if (wr_lo && aw_addr == `RRBS_OFF_FLAGS)
      flags <= w_data[`RRBS_FLAG_W-1:0];
    else if (exec)
    begin
      case (cmd_op)
        OP_ROTRC, OP_ROTRC_A: flags.carry <= rot_c;
        OP_SBC_A, OP_SBC_M:   flags <= sub_flags;
        default:              flags <= flags;
      endcase
    end
  end

  // Memory index register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_idx <= `RRBS_RST_IDX;
    else if (wr_lo && aw_addr == `RRBS_OFF_MIDX)
      mem_idx <= w_data[`RRBS_IDX_W-1:0];
  end

  // Data memory: software write or operation result
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < `RRBS_MEM_DEPTH; k++)
        mem[k] <= `RRBS_RST_BYTE;
    end
    else if (wr_lo && aw_addr == `RRBS_OFF_MDATA)
      mem[mem_idx] <= w_data[`RRBS_BYTE_W-1:0];
    else if (exec)
    begin
      case (cmd_op)
        OP_ROTR:  mem[mem_idx] <= rot_res;
        OP_ROTRC: mem[mem_idx] <= rot_res;
        OP_SBC_M: mem[mem_idx] <= sub_res;
        default:  mem[mem_idx] <= cur_mem;
      endcase
    end
  end

  // Status: last command and whether it was recognised
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      last_op <= OP_NONE;
      bad_op  <= 1'b0;
    end
    else if (exec)
    begin
      last_op <= cmd_op;
      case (cmd_op)
        OP_ROTR, OP_ROTR_A, OP_ROTRC, OP_ROTRC_A, OP_SBC_A, OP_SBC_M: bad_op <= 1'b0;
        default:                                                       bad_op <= 1'b1;
      endcase
    end
  end

  // Read decode
  always_comb
  begin
    next_rdata = {`RRBS_DATA_W{1'b0}};
    next_rresp = `RRBS_RESP_OKAY;
    case (s_axi_araddr)
      `RRBS_OFF_ACC:   next_rdata[`RRBS_BYTE_W-1:0] = acc;
      `RRBS_OFF_MIDX:  next_rdata[`RRBS_IDX_W-1:0]  = mem_idx;
      `RRBS_OFF_MDATA: next_rdata[`RRBS_BYTE_W-1:0] = cur_mem;
      `RRBS_OFF_CMD:   next_rdata[`RRBS_OP_W-1:0]   = last_op;
      `RRBS_OFF_FLAGS: next_rdata[`RRBS_FLAG_W-1:0] = flags;
      `RRBS_OFF_STAT:  next_rdata[0]                = bad_op;
      default:         next_rresp                   = `RRBS_RESP_ERR;
    endcase
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= {`RRBS_DATA_W{1'b0}};
      s_axi_rresp   <= `RRBS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Operation checks
  a_rotr_mem_keep: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_ROTR |=> cur_mem == {$past(cur_mem[0]), $past(cur_mem[7:1])}
      && flags == $past(flags) && acc == $past(acc))
    else $error("rotate right to memory wrong");

  a_rotr_acc_keep: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_ROTR_A |=> acc == {$past(cur_mem[0]), $past(cur_mem[7:1])}
      && cur_mem == $past(cur_mem) && flags == $past(flags))
    else $error("rotate right to accumulator wrong");

  a_rotrc_mem: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_ROTRC |=> cur_mem == {$past(flags.carry), $past(cur_mem[7:1])}
      && flags.carry == $past(cur_mem[0]) && acc == $past(acc))
    else $error("rotate through carry to memory wrong");

  a_rotrc_acc: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_ROTRC_A |=> acc == {$past(flags.carry), $past(cur_mem[7:1])}
      && flags.carry == $past(cur_mem[0]) && cur_mem == $past(cur_mem)
      && flags[`RRBS_FLAG_W-1:1] == $past(flags[`RRBS_FLAG_W-1:1]))
    else $error("rotate through carry to accumulator wrong");

  a_sbc_acc_val: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_SBC_A |=> acc == 8'($past(acc) - $past(cur_mem) - 8'(!$past(flags.carry)))
      && cur_mem == $past(cur_mem))
    else $error("borrow subtract to accumulator wrong");

  a_sbc_carry: assert property (@(posedge clk) disable iff (sys_rst)
    exec && (cmd_op == OP_SBC_A || cmd_op == OP_SBC_M) |=> flags.carry ==
      ({1'b0, $past(acc)} >= {1'b0, $past(cur_mem)} + {8'h00, !$past(flags.carry)}))
    else $error("borrow subtract carry wrong");

  a_sbc_zero: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_SBC_A ##1 1'b1 |-> flags.zero == (acc == `RRBS_RST_BYTE))
    else $error("borrow subtract zero flag wrong");

  a_sbcm_mem: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_SBC_M |=> cur_mem == 8'($past(acc) - $past(cur_mem)
      - 8'(!$past(flags.carry))) && acc == $past(acc))
    else $error("borrow subtract to memory wrong");

  a_sbc_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd_op == OP_SBC_A |=> flags.signed_wrap_flag ==
      (($past(acc[7]) != $past(cur_mem[7])) && (acc[7] != $past(acc[7])))
      && flags.signed_cmp_flag == ~(flags.signed_wrap_flag ^ acc[7]))
    else $error("borrow subtract signed flags wrong");

endmodule : rrbs_top

/* logic/rrbs_regs.svh */
// Register offsets, field positions and reset values of the rotate and borrow-subtract datapath
// What this block does
// - mem_rotate_right rotates memory byte right, bit 0 into bit 7, flags kept.
// - rotate_right_to_acc puts the rotated byte in the accumulator, memory and flags kept.
// - rotate_right_via_carry rotates byte and carry right, result back to memory.
// - rotate_right_via_carry_to_acc rotates through carry into accumulator, only carry changes.
// - sub_borrow_to_acc stores accumulator minus byte minus inverted carry in accumulator.
// - Borrow-subtract clears carry on negative result, sets it on zero or positive.
// - Borrow-subtract updates wrap, zero, aux borrow, carry, signed compare, chained zero.
// - sub_borrow_to_mem writes accumulator minus byte minus inverted carry to memory.
`ifndef RRBS_REGS_SVH
`define RRBS_REGS_SVH

`define RRBS_ADDR_W    8
`define RRBS_DATA_W    32
`define RRBS_BYTE_W    8
`define RRBS_MSB       7
`define RRBS_NIB_W     4
`define RRBS_OP_W      3
`define RRBS_IDX_W     4
`define RRBS_MEM_DEPTH 16
`define RRBS_FLAG_W    6

`define RRBS_OFF_ACC   8'h00
`define RRBS_OFF_MIDX  8'h04
`define RRBS_OFF_MDATA 8'h08
`define RRBS_OFF_CMD   8'h0C
`define RRBS_OFF_FLAGS 8'h10
`define RRBS_OFF_STAT  8'h14

`define RRBS_RST_BYTE  8'h00
`define RRBS_RST_IDX   4'h0
`define RRBS_RST_FLAGS 6'h00

`define RRBS_RESP_OKAY 2'h0
`define RRBS_RESP_ERR  2'h2

`endif

/* logic/rrbs_pkg.sv */
// Types shared by the rotate and borrow-subtract datapath
`include "rrbs_regs.svh"
package rrbs_pkg;

  // Operation codes written to the command register
  typedef enum logic [`RRBS_OP_W-1:0] {
    OP_NONE    = 3'h0,
    OP_ROTR    = 3'h1,
    OP_ROTR_A  = 3'h2,
    OP_ROTRC   = 3'h3,
    OP_ROTRC_A = 3'h4,
    OP_SBC_A   = 3'h5,
    OP_SBC_M   = 3'h6
  } rrbs_op_t;

  // Status flags, carry in the lowest bit
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_cmp_flag;
    logic signed_wrap_flag;
    logic zero;
    logic aux_borrow_flag;
    logic carry;
  } rrbs_flags_t;

endpackage : rrbs_pkg

/* logic/rrbs_rotate.sv */
// One-place right rotator, with or without carry in the loop
`timescale 1ns/1ps
`include "rrbs_regs.svh"
module rrbs_rotate
  import rrbs_pkg::*;
(
  input  logic [`RRBS_BYTE_W-1:0] operand,
  input  logic                    carry_in,
  input  logic                    via_carry,
  output logic [`RRBS_BYTE_W-1:0] result,
  output logic                    carry_out
);

  // Bits 0 to 6 each take their upper neighbour
  genvar i;
  generate
    for (i = 0; i < `RRBS_MSB; i++)
    begin : g_shift
      assign result[i] = operand[i+1];
    end
  endgenerate

  // Top bit from old bit 0 or old carry; bit 0 becomes carry
  assign result[`RRBS_MSB] = via_carry ? carry_in : operand[0];
  assign carry_out         = operand[0];

endmodule : rrbs_rotate

/* logic/rrbs_subc.sv */
// Subtract with borrow: a minus m minus inverted carry, with flags
`timescale 1ns/1ps
`include "rrbs_regs.svh"
module rrbs_subc
  import rrbs_pkg::*;
(
  input  logic [`RRBS_BYTE_W-1:0] acc_in,
  input  logic [`RRBS_BYTE_W-1:0] mem_in,
  input  logic                    carry_in,
  input  logic                    chain_in,
  output logic [`RRBS_BYTE_W-1:0] result,
  output rrbs_flags_t             flags_out
);

  logic [`RRBS_BYTE_W:0] full_sum;
  logic [`RRBS_NIB_W:0]  nib_sum;
  logic                  wrap;

  // Two's complement form: a + ~m + c
  assign full_sum = {1'b0, acc_in} + {1'b0, ~mem_in} + {8'h00, carry_in};
  assign nib_sum  = {1'b0, acc_in[`RRBS_NIB_W-1:0]}
                  + {1'b0, ~mem_in[`RRBS_NIB_W-1:0]} + {4'h0, carry_in};
  assign result   = full_sum[`RRBS_BYTE_W-1:0];
  assign wrap     = (acc_in[`RRBS_MSB] != mem_in[`RRBS_MSB])
                  && (result[`RRBS_MSB] != acc_in[`RRBS_MSB]);

  // Flag derivation as for the core's other subtract-with-carry forms
  always_comb
  begin
    flags_out.carry             = full_sum[`RRBS_BYTE_W];
    flags_out.aux_borrow_flag   = nib_sum[`RRBS_NIB_W];
    flags_out.zero              = (result == `RRBS_RST_BYTE);
    flags_out.signed_wrap_flag  = wrap;
    flags_out.signed_cmp_flag   = ~(wrap ^ result[`RRBS_MSB]);
    flags_out.chained_zero_flag = (result == `RRBS_RST_BYTE) & chain_in;
  end

endmodule : rrbs_subc

/* testbench/test_rotate_right_and_borrow_subtract.sv */
// Self-checking bench for the rotate and borrow-subtract datapath
`timescale 1ns/1ps
`include "rrbs_regs.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_rotate_right_and_borrow_subtract
  import rrbs_pkg::*;
;
  logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  wstrb, wr_strb;
  logic [1:0]  bresp, rresp;
  int          failures, checked;

  rrbs_top DUT (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // Free-running 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected {acc, mem, flags} after one command
  function automatic logic [21:0] model(input logic [2:0] op, input logic [7:0] a, m,
                                        input rrbs_flags_t f);
    logic [7:0]  d;
    logic [4:0]  h;
    logic [7:0]  ra, rm;
    rrbs_flags_t rf;
    ra = a;
    rm = m;
    rf = f;
    d  = a - m - 8'(!f.carry);
    h  = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'(f.carry);
    case (op)
      3'h1: rm = {m[0], m[7:1]};
      3'h2: ra = {m[0], m[7:1]};
      3'h3: {rm, rf.carry} = {f.carry, m};
      3'h4: {ra, rf.carry} = {f.carry, m};
      3'h5, 3'h6:
      begin
        if (op == 3'h5)
          ra = d;
        else
          rm = d;
        rf.carry             = ({1'b0, a} >= {1'b0, m} + 9'(!f.carry));
        rf.aux_borrow_flag   = h[4];
        rf.zero              = (d == 8'h00);
        rf.signed_wrap_flag  = (a[7] != m[7]) && (d[7] != a[7]);
        rf.signed_cmp_flag   = ~(rf.signed_wrap_flag ^ d[7]);
        rf.chained_zero_flag = rf.zero & f.zero;
      end
      default: ;
    endcase
    return {ra, rm, rf};
  endfunction : model

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= wr_strb;
    awprot  <= rnd[2:0];
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // AXI4-Lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arprot  <= rnd[5:3];
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Read a register and compare data and response
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask : chk_rd

  // Load operands, issue one command, check all results
  task automatic run_op(input logic [2:0] op, input logic [7:0] a, m, input logic [5:0] f,
                        input logic [3:0] ix);
    logic [21:0] e;
    logic [1:0]  r;
    wr(`RRBS_OFF_ACC, 32'(a), r);
    wr(`RRBS_OFF_MIDX, 32'(ix), r);
    wr(`RRBS_OFF_MDATA, 32'(m), r);
    wr(`RRBS_OFF_FLAGS, 32'(f), r);
    wr(`RRBS_OFF_CMD, 32'(op), r);
    `CHK(r, `RRBS_RESP_OKAY)
    e = model(op, a, m, rrbs_flags_t'(f));
    chk_rd(`RRBS_OFF_ACC, 32'(e[21:14]), `RRBS_RESP_OKAY);
    chk_rd(`RRBS_OFF_MDATA, 32'(e[13:6]), `RRBS_RESP_OKAY);
    chk_rd(`RRBS_OFF_FLAGS, 32'(e[5:0]), `RRBS_RESP_OKAY);
    // Last command readback and illegal-command status
    chk_rd(`RRBS_OFF_CMD, 32'(op), `RRBS_RESP_OKAY);
    chk_rd(`RRBS_OFF_STAT, 32'(op == 3'h0 || op == 3'h7), `RRBS_RESP_OKAY);
  endtask : run_op

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    logic [1:0] r;
    failures = 0;
    checked  = 0;
    rnd      = 32'h0000_9529;
    sys_rst  = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wstrb} = '0;
    wdata = 32'h0000_0000;
    wr_strb = 4'hf;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values
    chk_rd(`RRBS_OFF_ACC, 32'h0000_0000, `RRBS_RESP_OKAY);
    chk_rd(`RRBS_OFF_FLAGS, 32'h0000_0000, `RRBS_RESP_OKAY);
    chk_rd(`RRBS_OFF_MDATA, 32'h0000_0000, `RRBS_RESP_OKAY);
    // Write with lane 0 disabled is answered but ignored
    wr_strb = 4'he;
    wr(`RRBS_OFF_ACC, 32'h0000_00a5, r);
    `CHK(r, `RRBS_RESP_OKAY)
    wr_strb = 4'hf;
    chk_rd(`RRBS_OFF_ACC, 32'h0000_0000, `RRBS_RESP_OKAY);
    // Unmapped address refused both ways
    wr(8'h40, 32'h0000_00ff, r);
    `CHK(r, `RRBS_RESP_ERR)
    chk_rd(8'h40, 32'h0000_0000, `RRBS_RESP_ERR);
    // Corner cases: bit wrap, zero chain, negative, signed wrap
    run_op(3'h1, 8'h5a, 8'h01, 6'h3f, 4'h0);
    run_op(3'h2, 8'h00, 8'h80, 6'h00, 4'hf);
    run_op(3'h3, 8'h11, 8'h01, 6'h00, 4'h3);
    run_op(3'h4, 8'h22, 8'hfe, 6'h01, 4'h7);
    run_op(3'h5, 8'h00, 8'h00, 6'h05, 4'h1);
    run_op(3'h5, 8'h00, 8'h01, 6'h00, 4'h2);
    run_op(3'h6, 8'h80, 8'h01, 6'h01, 4'h9);
    run_op(3'h6, 8'h10, 8'h01, 6'h00, 4'ha);
    // Random operands, every opcode several times
    for (int i = 0; i < 48; i++)
    begin
      rnd = lfsr(rnd);
      run_op(3'(i), rnd[7:0], rnd[15:8], rnd[21:16], rnd[25:22]);
    end
    report_and_stop();
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule : test_rotate_right_and_borrow_subtract
